// [pkg/sac_pkg.sv]
package sac_pkg;
  localparam logic [7:0] ADDR_RESULT = 8'hD0;
  localparam logic [7:0] ADDR_CONTROL = 8'hD1;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_DONE = 6;
  localparam int BIT_START = 5;
  localparam int BIT_POWER = 4;
  localparam int RES_BITS = 8;
  localparam int STEP_DIV = 12;
  localparam int STEP_CNT_W = 4;
  localparam logic [STEP_CNT_W-1:0] STEP_LAST = 4'hB;
  // Oscillator cycles per conversion: 70 us at 8 MHz gives 560, 46 whole steps of 12
  localparam int CONV_TIME_NS = 70000;
  localparam int OSC_PERIOD_NS = 125;
  localparam int CONV_STEPS = (CONV_TIME_NS / OSC_PERIOD_NS) / STEP_DIV;
  localparam int SETTLE_STEPS = CONV_STEPS - RES_BITS;
  localparam int SEQ_W = 6;
  localparam int VECTOR_NUM = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sac_bus_t;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SETTLE,
    SAC_APPROX
  } sac_state_t;
endpackage

// [design/sac_step_div.sv]
`timescale 1ns/10ps
`default_nettype none
module sac_step_div (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic restart,
  output logic step
);
  logic [sac_pkg::STEP_CNT_W-1:0] cnt_q;

  // Divide by twelve; restart realigns so a new conversion gets a full first step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (restart || cnt_q == sac_pkg::STEP_LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step <= 1'b0;
    end else begin
      step <= !restart && (cnt_q == sac_pkg::STEP_LAST);
    end
  end
endmodule
`default_nettype wire

// [design/sac_control.sv]
// Summary of operation
// - Resolve 8 result bits by successive approximation, MSB first.
// - Step clock is the oscillator clock divided by twelve.
// - Conversion takes about 70 us worth of steps at 8 MHz.
// - Writing start one begins a conversion and clears the done flag.
// - Completion sets the done flag; result register is then valid.
// - Single-shot: idle after one result until start is written again.
// - Start written during a conversion abandons it and starts afresh.
// - Start bit is write-only and always reads as zero.
// - Interrupt request on vector four while done and enable are both one.
// - Done flag is read-only and serves as interrupt pending bit.
// - Power bit one powers converter; zero puts it in power-down.
// - Wait mode does not power off the comparator; only power bit does.
// - Reset stops conversion, loads control with 40h, interrupt masked.
// - Control: enable bit 7, done 6, start 5, power 4; bits 3-0 unused.
// - Result register is read-only 8-bit result, valid while done is one.
`timescale 1ns/10ps
`default_nettype none
module sac_control (
  input wire logic clock,
  input wire logic rst_n,
  input wire sac_pkg::sac_bus_t bus,
  output logic [7:0] rdata,
  input wire logic comp_in,
  input wire logic wait_mode,
  output logic [7:0] dac_code,
  output logic sample_en,
  output logic comp_power,
  output logic irq_req,
  output logic [2:0] irq_vector
);
  sac_pkg::sac_state_t state_q;
  logic irq_en_q;
  logic done_q;
  logic power_q;
  logic [7:0] result_q;
  logic [7:0] trial_q;
  logic [2:0] bit_idx_q;
  logic [sac_pkg::SEQ_W-1:0] settle_q;
  logic comp_meta_q;
  logic comp_sync_q;
  logic start_wr;
  logic ctrl_wr;
  logic step;
  logic wait_unused;

  assign ctrl_wr = bus.wr && (bus.addr == sac_pkg::ADDR_CONTROL);
  assign start_wr = ctrl_wr && bus.wdata[sac_pkg::BIT_START];
  // Power state ignores wait mode entirely
  assign wait_unused = wait_mode;

  sac_step_div sac_step_div_inst (
    .clock(clock),
    .rst_n(rst_n),
    .restart(start_wr),
    .step(step)
  );

  // Comparator output is analog-domain, so it is synchronised
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_in;
      comp_sync_q <= comp_meta_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= sac_pkg::CONTROL_RESET[sac_pkg::BIT_IRQ_EN];
      power_q <= sac_pkg::CONTROL_RESET[sac_pkg::BIT_POWER];
    end else if (ctrl_wr) begin
      irq_en_q <= bus.wdata[sac_pkg::BIT_IRQ_EN];
      power_q <= bus.wdata[sac_pkg::BIT_POWER];
    end
  end

  // Conversion sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sac_pkg::SAC_IDLE;
      trial_q <= '0;
      bit_idx_q <= '0;
      settle_q <= '0;
    end else if (start_wr) begin
      state_q <= sac_pkg::SAC_SETTLE;
      trial_q <= '0;
      bit_idx_q <= 3'h7;
      settle_q <= '0;
    end else if (step) begin
      unique case (state_q)
        sac_pkg::SAC_IDLE: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
        sac_pkg::SAC_SETTLE: begin
          // Settling steps pad the conversion to its documented length
          if (settle_q == sac_pkg::SEQ_W'(sac_pkg::SETTLE_STEPS - 1)) begin
            state_q <= sac_pkg::SAC_APPROX;
            trial_q <= 8'h80;
          end else begin
            settle_q <= settle_q + 1'b1;
          end
        end
        sac_pkg::SAC_APPROX: begin
          // Keep the trial bit if input is above the trial level, then try next
          if (!comp_sync_q) begin
            trial_q[bit_idx_q] <= 1'b0;
          end
          if (bit_idx_q == 3'h0) begin
            state_q <= sac_pkg::SAC_IDLE;
          end else begin
            bit_idx_q <= bit_idx_q - 1'b1;
            trial_q[bit_idx_q - 1'b1] <= 1'b1;
          end
        end
      endcase
    end
  end

  logic finish;
  assign finish = step && !start_wr && (state_q == sac_pkg::SAC_APPROX) && (bit_idx_q == 3'h0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= sac_pkg::CONTROL_RESET[sac_pkg::BIT_DONE];
    end else if (start_wr) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (finish) begin
      result_q <= {trial_q[7:1], comp_sync_q};
    end
  end

  // Read mux: start reads zero, bits 3-0 read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (bus.rd && bus.addr == sac_pkg::ADDR_CONTROL) begin
      rdata <= {irq_en_q, done_q, 1'b0, power_q, 4'h0};
    end else if (bus.rd && bus.addr == sac_pkg::ADDR_RESULT) begin
      rdata <= result_q;
    end else begin
      rdata <= '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_vector <= 3'(sac_pkg::VECTOR_NUM);
      dac_code <= '0;
      sample_en <= 1'b0;
      comp_power <= 1'b0;
    end else begin
      irq_req <= done_q && irq_en_q;
      irq_vector <= 3'(sac_pkg::VECTOR_NUM);
      dac_code <= trial_q;
      sample_en <= (state_q != sac_pkg::SAC_IDLE);
      comp_power <= power_q || (wait_unused && power_q);
    end
  end
endmodule
`default_nettype wire

// [sim/sac_comp_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sac_comp_model (
  input wire logic [7:0] level,
  input wire logic [7:0] dac_code,
  output logic comp_in
);
  // Input sits half a step above level, so trials up to level read high
  // Only one analog input is modelled, so a single level drives the comparator
  assign comp_in = (dac_code <= level);
endmodule
`default_nettype wire

// [sim/sac_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module sac_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire sac_pkg::sac_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic sample_en,
  input wire logic comp_power,
  input wire logic irq_req,
  input wire logic [2:0] irq_vector
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic ctl, go;
  logic [9:0] run_q;
  assign ctl = bus.wr && bus.addr == 8'hD1;
  assign go = ctl && bus.wdata[5];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) run_q <= 10'h000;
    else if (go) run_q <= 10'h000;
    else if (sample_en) run_q <= run_q + 10'h001;
  end
  sequence s_go;
    go ##1 !go;
  endsequence
  a_vector_four: assert property (irq_vector == 3'h4) else $error("vector");
  a_ctrl_rd_zero: assert property (bus.rd && bus.addr == 8'hD1 |=>
    !rdata[5] && rdata[3:0] == 4'h0) else $error("ctrl bits");
  a_other_rd_zero: assert property (bus.rd && bus.addr[7:1] != 7'h68 |=>
    rdata == 8'h00) else $error("unmapped read");
  a_start_irq_low: assert property (s_go |-> ##1 !irq_req) else $error("irq");
  a_start_runs: assert property (s_go |-> ##[0:1] sample_en) else $error("run");
  // Power bit lands one edge after the write, the registered pin one edge later
  a_power_follows: assert property (ctl |-> ##2 comp_power == $past(bus.wdata[4], 2))
    else $error("power");
  a_power_only_wr: assert property ($changed(comp_power) |-> $past(ctl, 2))
    else $error("power change");
  a_rise_on_start: assert property ($rose(sample_en) |-> $past(go) || $past(go, 2))
    else $error("self start");
  a_conv_length: assert property ($fell(sample_en) |->
    run_q >= 10'h221 && run_q <= 10'h22C) else $error("length");
endmodule
bind sac_control sac_checker sac_checker_inst (.*);
`default_nettype wire

// [sim/sac_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module sac_control_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wait_mode = 1'b0;
  logic comp_in, sample_en, comp_power, irq_req;
  logic [7:0] rdata, dac_code;
  logic [7:0] level = 8'hA5;
  logic [2:0] irq_vector;
  sac_pkg::sac_bus_t bus = '0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  sac_control sac_control_inst (.*);
  sac_comp_model sac_comp_model_inst (.*);
  initial forever #10 clock = ~clock;
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clock);
    bus.rd <= 1'b0;
    @(negedge clock);
    chk("rdata", rdata, exp);
  endtask
  task automatic done_wait;
    repeat (2) @(posedge clock);
    for (int n = 0; n < 700 && sample_en !== 1'b0; n++) @(posedge clock);
    @(negedge clock);
    chk("busy", {7'h00, sample_en}, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'hD1, 8'h40);
    rd(8'hD0, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hD1, 8'h10);
    wait_mode <= 1'b1;
    rd(8'hD1, 8'h50);
    chk("power", {7'h00, comp_power}, 8'h01);
    wr(8'hD1, 8'hB0);
    rd(8'hD1, 8'h90);
    done_wait();
    rd(8'hD1, 8'hD0);
    rd(8'hD0, 8'hA5);
    chk("irq", {7'h00, irq_req}, 8'h01);
    repeat (30) @(posedge clock);
    chk("idle", {7'h00, sample_en}, 8'h00);
    level <= 8'h3C;
    wr(8'hD1, 8'hB0);
    repeat (300) @(posedge clock);
    rd(8'hD0, 8'hA5);
    level <= 8'hC3;
    wr(8'hD1, 8'hB0);
    repeat (400) @(posedge clock);
    rd(8'hD1, 8'h90);
    done_wait();
    rd(8'hD0, 8'hC3);
    level <= 8'h5A;
    wr(8'hD1, 8'h30);
    done_wait();
    chk("irq", {7'h00, irq_req}, 8'h00);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'h5A);
    wr(8'hD1, 8'h80);
    rd(8'hD1, 8'hC0);
    chk("irq", {7'h00, irq_req}, 8'h01);
    chk("power", {7'h00, comp_power}, 8'h00);
    wr(8'hD1, 8'hB0);
    repeat (50) @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    chk("busy", {7'h00, sample_en}, 8'h00);
    rd(8'hD1, 8'h40);
    print_verdict();
  end
endmodule
`default_nettype wire
